// ### logic/exc_pkg.sv
// constants, types and register map of the interrupt dispatch and halt entry unit
// Contract
// - software levels 1-15 use slots 84 hex upward, one longword apart.
// - emulation start fault uses offset C8 and pushes ten parameters.
// - emulation continue fault uses offset CC and pushes no parameters.
// - external bus vectors take their table index from returned bits 15:2.
// - vector bit 0 clear: new priority follows request line, 14 to 17 hex.
// - vector bit 0 set: new priority forced to 17 hex.
// - halt saves program counter and status into saved registers 42, 43.
// - saved status keeps 31:16, 7:0; translation bit 15; code 13:8.
// - valid flag bit 14 is 0 when status valid, 1 when invalid.
// - halt saves current stack pointer, then loads interrupt stack pointer.
// - halt forces status longword 041F0000 and clears translation enable.
// - after saving, control passes to firmware at 20040000 hex.
// - halt code 3 also clears interval clock, summary and trap level registers.
// - codes: 6 kernel halt instruction, 2 external halt, 3 reset.
// - table entry low bits 11 halts with code 7, 10 with code 8.
package exc_pkg;
  // ---------------------------------------------------------------
  // vector table offsets and priorities
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_SOFT_BASE = 16'h0080;
  localparam logic [15:0] VEC_EMU_START = 16'h00c8;
  localparam logic [15:0] VEC_EMU_CONT = 16'h00cc;
  localparam logic [3:0] EMU_START_PARAMS = 4'ha;
  localparam logic [3:0] EMU_CONT_PARAMS = 4'h0;
  localparam logic [3:0] NO_PARAMS = 4'h0;
  localparam logic [4:0] PRIO_IRQ_BASE = 5'h14;
  localparam logic [4:0] PRIO_FORCED = 5'h17;
  localparam int unsigned VEC_IDX_LO = 2;
  localparam int unsigned VEC_IDX_HI = 15;
  localparam int unsigned VEC_FORCE_BIT = 0;
  localparam logic [1:0] ENTRY_BAD_HALT7 = 2'h3;
  localparam logic [1:0] ENTRY_BAD_HALT8 = 2'h2;
  // ---------------------------------------------------------------
  // halt entry
  // ---------------------------------------------------------------
  localparam logic [31:0] HALT_STATUS = 32'h041f_0000;
  localparam logic [31:0] FIRMWARE_PC = 32'h2004_0000;
  localparam logic [5:0] CODE_EXT_HALT = 6'h02;
  localparam logic [5:0] CODE_RESET = 6'h03;
  localparam logic [5:0] CODE_HALT_INSTR = 6'h06;
  localparam logic [5:0] CODE_VEC_11 = 6'h07;
  localparam logic [5:0] CODE_VEC_10 = 6'h08;
  localparam int unsigned SS_XLATE_BIT = 15;
  localparam int unsigned SS_VALID_BIT = 14;
  localparam int unsigned SS_CODE_LO = 8;
  localparam int unsigned SS_CODE_HI = 13;
  // ---------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_SAVED_PC = 8'h2a;
  localparam logic [7:0] IDX_SAVED_STATUS = 8'h2b;
  localparam logic [7:0] IDX_INT_STATUS = 8'h30;
  localparam logic [7:0] IDX_INT_MASK = 8'h31;
  localparam logic [7:0] IDX_CONTROL = 8'h32;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned NUM_EV = 3;
  localparam int unsigned EV_HALT = 0;
  localparam int unsigned EV_VEC_ERR = 1;
  localparam int unsigned EV_DISPATCH = 2;
  localparam int unsigned CTL_HALT_REQ = 0;
  localparam int unsigned CTL_EXT_EN = 1;
  localparam logic [1:0] CTL_RESET = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {DK_SOFT, DK_EXT, DK_EMU} disp_kind_e;

  // processor state offered to the unit
  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] status;
    logic [31:0] sp;
    logic [31:0] isp;
    logic translation_enable;
    logic status_invalid;
  } cpu_state_s;

  // one dispatch decision
  typedef struct packed {
    logic [15:0] offset;
    logic [4:0] priority_level;
    logic prio_change;
    logic [3:0] param_count;
  } dispatch_s;
endpackage : exc_pkg

// ### logic/exc_unit.sv
// interrupt dispatch and hardware halt entry with an AXI4-Lite register slave
module exc_unit (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // processor side
  input wire exc_pkg::cpu_state_s cpu,
  input wire logic soft_req,
  input wire logic [3:0] soft_level,
  input wire logic ext_req,
  input wire logic [1:0] irq_line,
  input wire logic [15:0] ext_vector,
  input wire logic emu_req,
  input wire logic first_part_done,
  input wire logic entry_valid,
  input wire logic [1:0] entry_low,
  input wire logic ext_halt,
  input wire logic halt_instr_kernel,
  output exc_pkg::dispatch_s dispatch,
  output logic dispatch_valid,
  output logic halt_busy,
  output logic pc_load,
  output logic [31:0] pc_out,
  output logic status_load,
  output logic [31:0] status_out,
  output logic sp_load,
  output logic [31:0] sp_out,
  output logic [31:0] saved_sp,
  output logic translation_clear,
  output logic timer_regs_clear,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [exc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [exc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import exc_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SAVE, H_FORCE, H_JUMP} halt_state_e;

  halt_state_e state_ff;
  logic halt_pend_ff;
  logic [5:0] code_ff;
  logic [31:0] saved_pc_ff;
  logic [31:0] saved_status_ff;
  logic [NUM_EV-1:0] ev_status_ff;
  logic [NUM_EV-1:0] ev_mask_ff;
  logic [1:0] control_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic disp_wait_ff;
  disp_kind_e kind;
  dispatch_s nxt_dispatch;
  logic [31:0] nxt_saved_status;
  logic any_disp;
  logic vec_bad;
  logic [5:0] vec_code;
  logic halt_trig;
  logic [5:0] trig_code;
  logic wr_go;
  logic rd_go;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic status_read;
  logic [NUM_EV-1:0] ev_set;

  // ---------------------------------------------------------------
  // interrupt and exception dispatch
  // ---------------------------------------------------------------
  // emulation faults win over external interrupts, which win over software levels
  always_comb begin
    if (emu_req) begin
      kind = DK_EMU;
    end else if (ext_req && control_ff[CTL_EXT_EN]) begin
      kind = DK_EXT;
    end else begin
      kind = DK_SOFT;
    end
  end

  assign any_disp = emu_req || (ext_req && control_ff[CTL_EXT_EN])
                    || (soft_req && soft_level != 4'h0);

  vector_select u_vector_select (
    .kind(kind),
    .soft_level(soft_level),
    .irq_line(irq_line),
    .ext_vector(ext_vector),
    .first_part_done(first_part_done),
    .disp(nxt_dispatch)
  );

  // dispatch is held off while a halt sequence owns the processor
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dispatch <= '0;
      dispatch_valid <= 1'b0;
      disp_wait_ff <= 1'b0;
    end else if (ce) begin
      dispatch_valid <= 1'b0;
      if (any_disp && state_ff == H_IDLE && !halt_pend_ff) begin
        dispatch <= nxt_dispatch;
        dispatch_valid <= 1'b1;
        disp_wait_ff <= 1'b1;
      end else if (entry_valid) begin
        disp_wait_ff <= 1'b0;
      end
    end
  end

  assign vec_bad = entry_valid && disp_wait_ff && entry_low[1];
  assign vec_code = (entry_low == ENTRY_BAD_HALT7) ? CODE_VEC_11 : CODE_VEC_10;

  // ---------------------------------------------------------------
  // halt entry sequence
  // ---------------------------------------------------------------
  // code per halt cause
  always_comb begin
    halt_trig = 1'b1;
    trig_code = CODE_HALT_INSTR;
    if (vec_bad) begin
      trig_code = vec_code;
    end else if (ext_halt || control_ff[CTL_HALT_REQ]) begin
      trig_code = CODE_EXT_HALT;
    end else if (!halt_instr_kernel) begin
      halt_trig = 1'b0;
    end
  end

  halt_status_pack u_halt_status_pack (
    .status(cpu.status),
    .translation_enable(cpu.translation_enable),
    .status_invalid(cpu.status_invalid),
    .code(code_ff),
    .saved(nxt_saved_status)
  );

  // a reset leaves a pending code 3 halt, taken after the release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      halt_pend_ff <= 1'b1;
      code_ff <= CODE_RESET;
    end else if (ce) begin
      if (state_ff == H_IDLE && halt_pend_ff) begin
        halt_pend_ff <= 1'b0;
      end else if (state_ff == H_IDLE && halt_trig) begin
        halt_pend_ff <= 1'b1;
        code_ff <= trig_code;
      end
    end
  end

  // sequence runs to the end, no trigger can enter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= H_IDLE;
    end else if (ce) begin
      unique case (state_ff)
        H_IDLE: if (halt_pend_ff) begin
          state_ff <= H_SAVE;
        end
        H_SAVE: state_ff <= H_FORCE;
        H_FORCE: state_ff <= H_JUMP;
        H_JUMP: state_ff <= H_IDLE;
      endcase
    end
  end

  // saved registers and forced processor state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      saved_pc_ff <= '0;
      saved_status_ff <= '0;
      saved_sp <= '0;
      status_load <= 1'b0;
      status_out <= '0;
      sp_load <= 1'b0;
      sp_out <= '0;
      translation_clear <= 1'b0;
      timer_regs_clear <= 1'b0;
      pc_load <= 1'b0;
      pc_out <= '0;
    end else if (ce) begin
      status_load <= 1'b0;
      sp_load <= 1'b0;
      translation_clear <= 1'b0;
      timer_regs_clear <= 1'b0;
      pc_load <= 1'b0;
      if (state_ff == H_SAVE) begin
        saved_pc_ff <= cpu.pc;
        saved_status_ff <= nxt_saved_status;
        saved_sp <= cpu.sp;
      end
      if (state_ff == H_FORCE) begin
        status_load <= 1'b1;
        status_out <= HALT_STATUS;
        translation_clear <= 1'b1;
        sp_load <= 1'b1;
        sp_out <= cpu.isp;
        timer_regs_clear <= (code_ff == CODE_RESET);
      end
      if (state_ff == H_JUMP) begin
        pc_load <= 1'b1;
        pc_out <= FIRMWARE_PC;
      end
    end
  end

  // busy from the pending flag until the jump, falling in the same cycle that pc_load rises
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      halt_busy <= 1'b1;
    end else if (ce) begin
      halt_busy <= (state_ff != H_IDLE && state_ff != H_JUMP) || halt_pend_ff;
    end
  end

  // ---------------------------------------------------------------
  // events and interrupt
  // ---------------------------------------------------------------
  assign ev_set[EV_HALT] = ce && state_ff == H_JUMP;
  assign ev_set[EV_VEC_ERR] = ce && vec_bad && state_ff == H_IDLE;
  assign ev_set[EV_DISPATCH] = ce && dispatch_valid;
  assign status_read = rd_go && rd_idx == IDX_INT_STATUS;

  // read clears, a new event in the same cycle still lands
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ev_status_ff <= '0;
      irq <= 1'b0;
    end else begin
      if (ce) begin
        ev_status_ff <= (status_read ? '0 : ev_status_ff) | ev_set;
        irq <= |(((status_read ? '0 : ev_status_ff) | ev_set) & ev_mask_ff);
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_idx = awaddr_ff[ADDR_W-1:2];
  assign rd_go = s_axi_arvalid && s_axi_arready && ce;
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  // address and data are taken in either order, response after both
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff <= s_axi_wdata;
        w_held_ff <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_idx == IDX_INT_MASK || wr_idx == IDX_CONTROL)
                       ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // writable registers; only byte lane 0 carries bits
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ev_mask_ff <= '0;
      control_ff <= CTL_RESET;
    end else if (ce) begin
      if (control_ff[CTL_HALT_REQ] && state_ff == H_IDLE) begin
        control_ff[CTL_HALT_REQ] <= 1'b0;
      end
      if (wr_go && s_axi_wstrb[0]) begin
        if (wr_idx == IDX_INT_MASK) begin
          ev_mask_ff <= wdata_ff[NUM_EV-1:0];
        end
        if (wr_idx == IDX_CONTROL) begin
          control_ff <= wdata_ff[1:0];
        end
      end
    end
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (rd_idx)
          IDX_SAVED_PC: s_axi_rdata <= saved_pc_ff;
          IDX_SAVED_STATUS: s_axi_rdata <= saved_status_ff;
          IDX_INT_STATUS: s_axi_rdata <= {29'h0, ev_status_ff};
          IDX_INT_MASK: s_axi_rdata <= {29'h0, ev_mask_ff};
          IDX_CONTROL: s_axi_rdata <= {30'h0, control_ff};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_emu_start_slot: assert property (dispatch_valid && dispatch.param_count == EMU_START_PARAMS
    |-> dispatch.offset == VEC_EMU_START) else $error("start fault slot wrong");
  a_emu_cont_params: assert property (dispatch_valid && dispatch.offset == VEC_EMU_CONT
    |-> dispatch.param_count == 4'h0) else $error("continue fault params");
  a_ext_forced_prio: assert property (ce && any_disp && state_ff == H_IDLE && !halt_pend_ff
    && !emu_req && ext_req && control_ff[CTL_EXT_EN] && ext_vector[0]
    |=> dispatch.priority_level == PRIO_FORCED) else $error("forced priority");
  a_ext_index: assert property (ce && any_disp && state_ff == H_IDLE && !halt_pend_ff
    && !emu_req && ext_req && control_ff[CTL_EXT_EN]
    |=> dispatch.offset == {$past(ext_vector[15:2]), 2'h0}) else $error("ext index");
  a_ext_line_prio: assert property (ce && any_disp && state_ff == H_IDLE && !halt_pend_ff
    && !emu_req && ext_req && control_ff[CTL_EXT_EN] && !ext_vector[0] && irq_line == 2'h3
    |=> dispatch.priority_level == 5'h17) else $error("line priority");
  a_halt_status_force: assert property (ce && state_ff == H_FORCE
    |=> status_load && status_out == HALT_STATUS && translation_clear) else $error("force");
  a_halt_jump_order: assert property (status_load && ce |=> pc_load && pc_out == FIRMWARE_PC)
    else $error("jump not after force");
  a_halt_no_dispatch: assert property (state_ff != H_IDLE |-> !dispatch_valid [*2])
    else $error("dispatch during halt");
  a_code3_clear: assert property (timer_regs_clear |-> code_ff == CODE_RESET)
    else $error("clear without reset code");
  a_saved_code: assert property (ce && state_ff == H_SAVE
    |=> saved_status_ff[13:8] == $past(code_ff) && saved_pc_ff == $past(cpu.pc))
    else $error("saved status");
  c_ext_dispatch: cover property (dispatch_valid && dispatch.prio_change
    && dispatch.offset >= 16'h0100);
  c_bad_entry: cover property (ev_set[EV_VEC_ERR]);
  c_halt_done: cover property (pc_load && code_ff == CODE_EXT_HALT);
endmodule // exc_unit

// ### logic/halt_status_pack.sv
// builds the saved status word from status, translation bit, code and valid flag
module halt_status_pack (
  input wire logic [31:0] status,
  input wire logic translation_enable,
  input wire logic status_invalid,
  input wire logic [5:0] code,
  output logic [31:0] saved
);
  import exc_pkg::*;

  always_comb begin
    saved = status;
    saved[SS_XLATE_BIT] = translation_enable;
    saved[SS_VALID_BIT] = status_invalid;
    saved[SS_CODE_HI:SS_CODE_LO] = code;
  end
endmodule // halt_status_pack

// ### logic/vector_select.sv
// vector offset, parameter count and new priority for one dispatch
module vector_select (
  input wire exc_pkg::disp_kind_e kind,
  input wire logic [3:0] soft_level,
  input wire logic [1:0] irq_line,
  input wire logic [15:0] ext_vector,
  input wire logic first_part_done,
  output exc_pkg::dispatch_s disp
);
  import exc_pkg::*;

  // pick the slot for the requested kind
  always_comb begin
    disp = '0;
    unique case (kind)
      DK_SOFT: begin
        disp.offset = VEC_SOFT_BASE + {10'h000, soft_level, 2'h0};
        disp.priority_level = {1'b0, soft_level};
        disp.prio_change = 1'b1;
        disp.param_count = NO_PARAMS;
      end
      DK_EXT: begin
        disp.offset = {ext_vector[VEC_IDX_HI:VEC_IDX_LO], 2'h0};
        disp.priority_level = ext_vector[VEC_FORCE_BIT] ? PRIO_FORCED
                              : PRIO_IRQ_BASE + {3'h0, irq_line};
        disp.prio_change = 1'b1;
        disp.param_count = NO_PARAMS;
      end
      DK_EMU: begin
        disp.offset = first_part_done ? VEC_EMU_CONT : VEC_EMU_START;
        disp.param_count = first_part_done ? EMU_CONT_PARAMS : EMU_START_PARAMS;
      end
      default: disp = '0;
    endcase
  end
endmodule // vector_select

// ### testbench/ext_intr_model.sv
// far side: external vector source and table-entry fetch
module ext_intr_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] vec_sel,
  input wire logic [1:0] low_sel,
  input wire logic dispatch_valid,
  output logic [15:0] ext_vector,
  output logic entry_valid,
  output logic [1:0] entry_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] low_ff;
  // bit 0 picked per scenario; the bench, as service code, checks the level taken
  assign ext_vector = (vec_sel < 16'h0100) ? 16'h0100 : vec_sel;
  // entry fetch; off-strobe bits toggle so stale bits never match
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      entry_valid <= 1'h0;
      low_ff <= 2'h0;
    end else begin
      entry_valid <= dispatch_valid;
      low_ff <= dispatch_valid ? low_sel : ~low_ff;
    end
  end
  assign entry_low = low_ff;
endmodule // ext_intr_model

// ### testbench/interrupt_vector_halt_entry_test.sv
// bench for the interrupt dispatch and halt entry unit
module interrupt_vector_halt_entry_test;
  timeunit 1ns;
  timeprecision 1ns;
  import exc_pkg::*;
  logic ref_clk = 0, rst = 1, ce = 1, soft_req = 0, ext_req = 0, emu_req = 0;
  logic first_part_done = 0, ext_halt = 0, halt_instr_kernel = 0, entry_valid;
  logic dispatch_valid, halt_busy, irq, pc_load, status_load, sp_load;
  logic translation_clear, timer_regs_clear;
  logic [3:0] soft_level = 0, s_axi_wstrb = 4'hf;
  logic [1:0] irq_line = 0, entry_low, low_sel = 0, s_axi_bresp, s_axi_rresp;
  logic [15:0] ext_vector, vec_sel = 16'h0100;
  logic [31:0] pc_out, status_out, sp_out, saved_sp, s_axi_rdata, s_axi_wdata = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  cpu_state_s cpu = '0;
  dispatch_s dispatch;
  int err_count = 0, total_checks = 0, n_tclr = 0, n_xclr = 0;

  exc_unit dut_u (.ref_clk, .rst, .ce, .cpu, .soft_req, .soft_level, .ext_req,
    .irq_line, .ext_vector, .emu_req, .first_part_done, .entry_valid, .entry_low,
    .ext_halt, .halt_instr_kernel, .dispatch, .dispatch_valid, .halt_busy, .pc_load,
    .pc_out, .status_load, .status_out, .sp_load, .sp_out, .saved_sp,
    .translation_clear, .timer_regs_clear, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ext_intr_model far_u (.ref_clk, .rst, .vec_sel, .low_sel, .dispatch_valid,
    .ext_vector, .entry_valid, .entry_low);

  initial forever #5 ref_clk = ~ref_clk;
  // pulse tallies; read only several edges after the pulses
  always @(posedge ref_clk) begin
    if (timer_regs_clear === 1'h1) n_tclr++;
    if (translation_clear === 1'h1) n_xclr++;
  end
  // watchdog well beyond the few hundred cycles needed
  initial begin
    #100us;
    err_count++;
    end_sim;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // bus master: hold each channel until its own handshake edge
  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic wait_jump;
    int i;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pc_load !== 1'h1 && i < 40);
    chk(pc_load, 1);
    chk(pc_out, FIRMWARE_PC);
  endtask
  // one request for one cycle, then the registered answer
  task automatic disp(input logic [3:0] req, input logic [15:0] v, input logic [1:0] ln,
      input logic [3:0] lv, input logic [15:0] eo, input logic [5:0] ep, input logic [3:0] en);
    @(posedge ref_clk);
    {first_part_done, emu_req, ext_req, soft_req} <= req;
    vec_sel <= v;
    irq_line <= ln;
    soft_level <= lv;
    @(posedge ref_clk);
    {emu_req, ext_req, soft_req} <= 3'h0;
    @(posedge ref_clk);
    chk(dispatch_valid, 1);
    chk(dispatch.offset, eo);
    chk({dispatch.prio_change, dispatch.priority_level & {5{dispatch.prio_change}}}, ep);
    chk(dispatch.param_count, en);
  endtask
  task automatic t_disp;
    logic [15:0] v;
    logic [4:0] p;
    for (int l = 1; l < 16; l++) begin
      disp(4'h1, 16'h0100, 2'h0, l[3:0], 16'h0080 + 16'(4 * l), {2'h2, l[3:0]}, 4'h0);
    end
    for (int n = 0; n < 8; n++) begin
      v = {2'h0, n[1:0], 10'h104, 1'h0, n[2]};
      p = n[2] ? 5'h17 : 5'h14 + 5'(n[1:0]);
      disp(4'h2, v, n[1:0], 4'h0, {v[15:2], 2'h0}, {1'h1, p}, 4'h0);
    end
    disp(4'h2, 16'hfffd, 2'h1, 4'h0, 16'hfffc, 6'h37, 4'h0);
    disp(4'h4, 16'h0100, 2'h0, 4'h0, 16'h00c8, 6'h00, 4'ha);
    disp(4'hc, 16'h0100, 2'h0, 4'h0, 16'h00cc, 6'h00, 4'h0);
    $display("dispatch test done");
  endtask
  // cause 0 pin, 1 halt instruction, 2 control bit, 3 bad table entry
  task automatic do_halt(input logic [1:0] cause, input logic [1:0] lo, input logic [5:0] code,
      input logic x);
    logic [31:0] d;
    logic [1:0] r;
    int t0, x0;
    cpu_state_s c;
    c = '{32'h1000_0400, 32'h03c0_81a5, 32'h7ffe_0000, 32'h8000_1000, x, ~x};
    t0 = n_tclr;
    x0 = n_xclr;
    @(posedge ref_clk);
    cpu <= c;
    low_sel <= lo;
    soft_level <= 4'h1;
    case (cause)
      2'h0: ext_halt <= 1'h1;
      2'h1: halt_instr_kernel <= 1'h1;
      2'h2: axi_wr(IDX_CONTROL, 32'h3, r);
      default: soft_req <= 1'h1;
    endcase
    @(posedge ref_clk);
    {ext_halt, halt_instr_kernel, soft_req} <= 3'h0;
    wait_jump;
    chk(status_out, HALT_STATUS);
    chk(sp_out, c.isp);
    chk(saved_sp, c.sp);
    axi_rd(IDX_SAVED_PC, d, r);
    chk(d, c.pc);
    axi_rd(IDX_SAVED_STATUS, d, r);
    chk(d, {c.status[31:16], x, ~x, code, c.status[7:0]});
    chk(n_tclr - t0, 0);
    chk(n_xclr - x0, 1);
    low_sel <= 2'h0;
    $display("halt test code %h done", code);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    logic a;
    axi_rd(IDX_INT_STATUS, d, r);
    disp(4'h1, 16'h0100, 2'h0, 4'h3, 16'h008c, 6'h23, 4'h0);
    axi_wr(IDX_INT_MASK, 32'h7, r);
    axi_rd(IDX_INT_MASK, d, r);
    chk(d[2:0], 3'h7);
    a = irq;
    axi_wr(IDX_INT_MASK, 32'h0, r);
    repeat (2) @(posedge ref_clk);
    chk(a, 1);
    chk(irq, 0);
    axi_rd(IDX_INT_STATUS, d, r);
    chk(d[2], 1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 0);
    axi_rd(IDX_INT_STATUS, d, r);
    chk(d, 0);
    axi_rd(8'h00, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 0);
    axi_wr(IDX_SAVED_PC, 32'h5, r);
    chk(r, RESP_SLVERR);
    $display("register test done");
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    wait_jump;
    axi_rd(IDX_SAVED_STATUS, d, r);
    chk(d[13:8], CODE_RESET);
    chk(n_tclr, 1);
    $display("reset halt test done");
    t_disp;
    do_halt(2'h0, 2'h0, CODE_EXT_HALT, 1'h0);
    do_halt(2'h1, 2'h0, CODE_HALT_INSTR, 1'h1);
    do_halt(2'h2, 2'h0, CODE_EXT_HALT, 1'h1);
    do_halt(2'h3, 2'h3, CODE_VEC_11, 1'h0);
    do_halt(2'h3, 2'h2, CODE_VEC_10, 1'h1);
    t_regs;
    end_sim;
  end
endmodule // interrupt_vector_halt_entry_test
